/* hdl/dsr_device.sv */
// Drive end: decodes recalibrate and security commands, reports error and status
// Function
// - F6h lock-disable; report aborted, ready, settled, error
// - Any 1xh code recalibrates heads to cylinder zero
// - Home failure sets track-zero-missing and error
// - Recalibrate reports aborted, track-zero, ready, settled, error
// - Lock-disable takes exactly one sector before checking
// - Word 0 bit 0 picks user or master
// - Password from words 1-16; rest ignored
// - Matching password clears the lock feature
// - Master password stays unchanged on disable
// - Host issues lock-disable only when unlocked
// - F3h arms erase, no data transfer
// - Arming must directly precede full erase
// - Arming must directly precede format
// - Arming reports aborted, ready, settled, error only
// - Unarmed full erase is aborted
// - Frozen mode rejects lock-disable until power-off
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dsr_device (
    input wire logic pclk,
    input wire logic presetn,
    dsr_link_if.dev link,
    input wire logic [255:0] user_password,
    input wire logic [255:0] master_password,
    input wire logic lock_set,
    input wire logic [15:0] head_cylinder,
    input wire logic head_fault,
    output logic head_step_in,
    output logic lock_enabled,
    output logic frozen,
    output logic erase_go
);
    import dsr_pkg::*;

    // Whole drive state in one register; one process builds its next value
    typedef struct packed {
        dsr_state_t st;
        logic [7:0] word_idx;
        logic sel_master;
        logic [255:0] pw;
        logic [15:0] seek_cnt;
        logic armed;
        logic lock;
        logic frz;
        logic step;
        logic erase;
        logic data_req;
        logic done;
        logic [7:0] err;
        logic [7:0] sts;
    } dsr_dev_t;

    dsr_dev_t s_q;
    dsr_dev_t s_d;

    // Only bits the command may report survive; everything else reads zero
    function automatic logic [7:0] ok_status(input logic failed);
        ok_status = ST_READY_BIT | ST_SETTLED_BIT | (failed ? ST_ERROR_BIT : 8'h00);
    endfunction

    // Recalibrate owns a whole nibble of codes, so any low nibble is taken
    function automatic logic is_recal(input logic [7:0] code);
        is_recal = code[7:4] == CMD_RECAL_NIBBLE;
    endfunction

    // Both media-wiping commands need the arming command just before them
    function automatic logic needs_arming(input logic [7:0] code);
        needs_arming = code == CMD_ERASE_UNIT || code == CMD_FORMAT;
    endfunction

    // Stored passwords are only read here, so the master survives a disable
    function automatic logic pw_matches(input logic [255:0] got, input logic [255:0] want);
        pw_matches = got == want;
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.step = 1'b0;
        s_d.erase = 1'b0;
        case (s_q.st)
            DSR_IDLE: begin
                if (link.cmd_valid) begin
                    // A new command clears the flags of the last one
                    s_d.err = 8'h00;
                    s_d.sts = 8'h00;
                    if (is_recal(link.cmd_code)) begin
                        s_d.seek_cnt = 16'h0000;
                        s_d.st = DSR_SEEK;
                        s_d.armed = 1'b0;
                    end else if (link.cmd_code == CMD_LOCK_DISABLE) begin
                        s_d.armed = 1'b0;
                        if (s_q.frz) begin
                            s_d.err = ERR_ABORTED_BIT;
                            s_d.sts = ok_status(1'b1);
                            s_d.st = DSR_DONE;
                        end else begin
                            s_d.word_idx = 8'h00;
                            s_d.data_req = 1'b1;
                            s_d.st = DSR_RECV;
                        end
                    end else if (link.cmd_code == CMD_ERASE_ARM) begin
                        s_d.armed = 1'b1;
                        s_d.sts = ok_status(1'b0);
                        s_d.st = DSR_DONE;
                    end else if (needs_arming(link.cmd_code)) begin
                        if (s_q.armed && !s_q.frz) begin
                            s_d.erase = 1'b1;
                            if (link.cmd_code == CMD_ERASE_UNIT) begin
                                s_d.lock = 1'b0;
                            end
                            s_d.sts = ok_status(1'b0);
                        end else begin
                            s_d.err = ERR_ABORTED_BIT;
                            s_d.sts = ok_status(1'b1);
                        end
                        s_d.armed = 1'b0;
                        s_d.st = DSR_DONE;
                    end else if (link.cmd_code == CMD_FREEZE) begin
                        s_d.frz = 1'b1;
                        s_d.armed = 1'b0;
                        s_d.sts = ok_status(1'b0);
                        s_d.st = DSR_DONE;
                    end else begin
                        s_d.armed = 1'b0;
                        s_d.err = ERR_ABORTED_BIT;
                        s_d.sts = ok_status(1'b1);
                        s_d.st = DSR_DONE;
                    end
                end
            end
            DSR_SEEK: begin
                // Step toward home; a fault or the step limit ends it as a miss
                if (head_cylinder == CYL_HOME) begin
                    s_d.sts = ok_status(1'b0);
                    s_d.st = DSR_DONE;
                end else if (head_fault || s_q.seek_cnt == SEEK_LIMIT) begin
                    s_d.err = ERR_TRK0_BIT;
                    s_d.sts = ok_status(1'b1);
                    s_d.st = DSR_DONE;
                end else if (!s_q.step) begin
                    // Step every other cycle, so the next compare sees the moved head
                    s_d.step = 1'b1;
                    s_d.seek_cnt = s_q.seek_cnt + CYL_STEP;
                end
            end
            DSR_RECV: begin
                if (link.data_valid) begin
                    // Reserved control bits and words after the password go unused
                    if (s_q.word_idx == 8'h00) begin
                        s_d.sel_master = link.data_word[0];
                    end else if (s_q.word_idx >= PW_FIRST && s_q.word_idx <= PW_LAST) begin
                        s_d.pw = {link.data_word, s_q.pw[255:16]};
                    end
                    s_d.word_idx = s_q.word_idx + 8'h01;
                    if (s_q.word_idx == WORD_LAST) begin
                        s_d.data_req = 1'b0;
                        s_d.st = DSR_CHECK;
                    end
                end
            end
            DSR_CHECK: begin
                if (pw_matches(s_q.pw,
                               s_q.sel_master ? master_password : user_password)) begin
                    s_d.lock = 1'b0;
                    s_d.sts = ok_status(1'b0);
                end else begin
                    s_d.err = ERR_ABORTED_BIT;
                    s_d.sts = ok_status(1'b1);
                end
                s_d.st = DSR_DONE;
            end
            DSR_DONE: begin
                // Flags stand until the next command is taken
                s_d.done = 1'b1;
                s_d.st = DSR_IDLE;
            end
            default: begin
                s_d.st = DSR_IDLE;
            end
        endcase
        // A lock request wins over a disable that ends in the same cycle
        if (lock_set) begin
            s_d.lock = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Power-up leaves the drive unlocked, unarmed and not frozen
            s_q <= '0;
            s_q.st <= DSR_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Every link and side output is a register bit
    assign link.data_req = s_q.data_req;
    assign link.done = s_q.done;
    assign link.error_flags = s_q.err;
    assign link.status_flags = s_q.sts;
    assign head_step_in = s_q.step;
    assign lock_enabled = s_q.lock;
    assign frozen = s_q.frz;
    assign erase_go = s_q.erase;
endmodule
`default_nettype wire

/* hdl/dsr_pkg.sv */
// Shared constants and types for the drive security and recalibrate command block
package dsr_pkg;
    localparam logic [7:0] CMD_LOCK_DISABLE = 8'hf6;
    localparam logic [7:0] CMD_ERASE_ARM = 8'hf3;
    localparam logic [7:0] CMD_ERASE_UNIT = 8'hf4;
    localparam logic [7:0] CMD_FORMAT = 8'hf7;
    localparam logic [7:0] CMD_FREEZE = 8'hf5;
    localparam logic [3:0] CMD_RECAL_NIBBLE = 4'h1;
    localparam logic [7:0] WORD_LAST = 8'hff;
    localparam logic [7:0] PW_FIRST = 8'h01;
    localparam logic [7:0] PW_LAST = 8'h10;
    localparam logic [7:0] ERR_ABORTED_BIT = 8'h04;
    localparam logic [7:0] ERR_TRK0_BIT = 8'h02;
    localparam logic [7:0] ST_READY_BIT = 8'h40;
    localparam logic [7:0] ST_SETTLED_BIT = 8'h10;
    localparam logic [7:0] ST_ERROR_BIT = 8'h01;
    localparam int CYL_W = 16;
    localparam logic [CYL_W-1:0] CYL_STEP = 16'h0001;
    localparam logic [CYL_W-1:0] CYL_HOME = 16'h0000;
    localparam logic [15:0] SEEK_LIMIT = 16'hffff;
    // APB register offsets of the host controller
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_CLR = 8'h10;
    localparam logic [7:0] REG_IRQ_EN = 8'h14;
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_WREQ = 2;
    typedef enum logic [2:0] {
        DSR_IDLE = 3'b000,
        DSR_SEEK = 3'b001,
        DSR_RECV = 3'b011,
        DSR_CHECK = 3'b010,
        DSR_DONE = 3'b110
    } dsr_state_t;
endpackage

/* hdl/dsr_link_if.sv */
// Task-file link between host controller and drive command handler
`timescale 1ns/10ps
`default_nettype none
interface dsr_link_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic data_valid;
    logic [15:0] data_word;
    logic data_req;
    logic done;
    logic [7:0] error_flags;
    logic [7:0] status_flags;
    modport dev (input cmd_valid, cmd_code, data_valid, data_word,
        output data_req, done, error_flags, status_flags);
    modport host (output cmd_valid, cmd_code, data_valid, data_word,
        input data_req, done, error_flags, status_flags);
endinterface
`default_nettype wire

/* hdl/dsr_host.sv */
// Host end: APB-programmed controller that issues commands and streams the data sector
`timescale 1ns/10ps
`default_nettype none
module dsr_host (
    input wire logic pclk,
    input wire logic presetn,
    dsr_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import dsr_pkg::*;

    typedef struct packed {
        logic cmd_valid;
        logic [7:0] cmd_code;
        logic data_valid;
        logic [15:0] data_word;
        logic [7:0] err;
        logic [7:0] sts;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [31:0] rdata;
        logic slverr;
        logic irq;
        logic ready;
    } dsr_host_t;

    dsr_host_t h_q;
    dsr_host_t h_d;
    logic acc;
    logic setup;
    logic [IRQ_W-1:0] ev;

    always_comb begin
        h_d = h_q;
        // No wait state: answer and error are registered in setup, stand in access
        setup = psel && !penable;
        acc = psel && penable && h_q.ready;
        h_d.ready = setup;
        h_d.cmd_valid = 1'b0;
        h_d.data_valid = 1'b0;
        h_d.slverr = 1'b0;
        ev = '0;
        ev[IRQ_DONE] = link.done;
        ev[IRQ_ERR] = link.done && |(link.status_flags & ST_ERROR_BIT);
        ev[IRQ_WREQ] = link.data_req && !h_q.data_valid;
        if (link.done) begin
            h_d.err = link.error_flags;
            h_d.sts = link.status_flags;
        end
        if (acc && pwrite) begin
            if (paddr == REG_CMD) begin
                // Software must send F3h right before erase or format
                h_d.cmd_valid = 1'b1;
                h_d.cmd_code = pwdata[7:0];
            end else if (paddr == REG_DATA) begin
                h_d.data_valid = link.data_req;
                h_d.data_word = pwdata[15:0];
            end else if (paddr == REG_IRQ_CLR) begin
                h_d.irq_stat = h_q.irq_stat & ~pwdata[IRQ_W-1:0];
            end else if (paddr == REG_IRQ_EN) begin
                h_d.irq_en = pwdata[IRQ_W-1:0];
            end
        end
        if (setup && pwrite) begin
            h_d.slverr = !(paddr == REG_CMD || paddr == REG_DATA ||
                           paddr == REG_IRQ_CLR || paddr == REG_IRQ_EN);
        end else if (setup) begin
            if (paddr == REG_RESULT) begin
                h_d.rdata = {15'h0000, link.data_req, h_q.err, h_q.sts};
            end else if (paddr == REG_IRQ_STAT) begin
                h_d.rdata = {29'h00000000, h_q.irq_stat};
            end else if (paddr == REG_IRQ_EN) begin
                h_d.rdata = {29'h00000000, h_q.irq_en};
            end else begin
                h_d.rdata = 32'h00000000;
                h_d.slverr = !(paddr == REG_CMD || paddr == REG_DATA);
            end
        end
        // Set wins over a clear in the same cycle
        h_d.irq_stat = h_d.irq_stat | ev;
        h_d.irq = |(h_d.irq_stat & h_d.irq_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    // No access waits: pready, prdata and pslverr all come from flops loaded in setup
    assign pready = h_q.ready;
    assign prdata = h_q.rdata;
    assign pslverr = h_q.slverr;
    assign irq = h_q.irq;
    assign link.cmd_valid = h_q.cmd_valid;
    assign link.cmd_code = h_q.cmd_code;
    assign link.data_valid = h_q.data_valid;
    assign link.data_word = h_q.data_word;
endmodule
`default_nettype wire

/* testbench/dsr_link_props.sv */
// Assertions on the task-file link between the two ends
`timescale 1ns/10ps
`default_nettype none
module dsr_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic data_req,
    input wire logic done,
    input wire logic [7:0] error_flags,
    input wire logic [7:0] status_flags
);
    import dsr_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire arm = cmd_valid && cmd_code == CMD_ERASE_ARM;
    done_pulse_a: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    arm_time_a: assert property (arm |-> ##2 done)
        else $error("erase arming answered late");
    arm_nodata_a: assert property (arm |-> !data_req [*3])
        else $error("erase arming asked for data");
    arm_flags_a: assert property (arm |-> ##2 (status_flags == 8'h50 && error_flags == 8'h00))
        else $error("erase arming flags wrong");
    err_bits_a: assert property (done |-> (error_flags & 8'hf9) == 8'h00)
        else $error("unused error bit set");
    sts_bits_a: assert property (done |-> (status_flags & 8'hae) == 8'h00)
        else $error("unused status bit set");
    err_sts_a: assert property (done |-> status_flags[0] == (error_flags != 8'h00))
        else $error("error status disagrees with error flags");
    req_done_a: assert property (data_req |-> !done)
        else $error("done while sector still wanted");
    sector_end_a: assert property ($fell(data_req) |-> ##[1:3] done)
        else $error("no answer after the sector");
    arm_c: cover property (arm ##2 done);
    sector_c: cover property ($fell(data_req));
    abort_c: cover property (done && error_flags[2]);
endmodule
`default_nettype wire

/* testbench/drive_security_recal_cmds_tb.sv */
// Testbench: host and drive ends joined over the task-file link
`timescale 1ns/10ps
`default_nettype none
module drive_security_recal_cmds_tb;
    import dsr_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic rerr;
    logic pready, pslverr, irq, step, lock_en, frozen, ego;
    logic [255:0] upw = '0, mpw = '0;
    logic lock_set = 1'b0, fault = 1'b0;
    logic [15:0] cyl = 16'h0;
    logic [15:0] sec [256];
    int seed = 32'h51ca13b6;
    int n_errors = 0, checked = 0, dones = 0, goes = 0;
    dsr_link_if link ();
    dsr_device i_dsr_device (.pclk(pclk), .presetn(presetn), .link(link.dev),
        .user_password(upw), .master_password(mpw), .lock_set(lock_set),
        .head_cylinder(cyl), .head_fault(fault), .head_step_in(step),
        .lock_enabled(lock_en), .frozen(frozen), .erase_go(ego));
    dsr_host i_dsr_host (.pclk(pclk), .presetn(presetn), .link(link.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    dsr_link_props i_dsr_link_props (.pclk(pclk), .presetn(presetn),
        .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .data_req(link.data_req),
        .done(link.done), .error_flags(link.error_flags), .status_flags(link.status_flags));
    always #10 pclk = ~pclk;
    // Head model: a fault freezes the arm so home is never reached
    always @(posedge pclk) begin
        if (step === 1'b1 && !fault) cyl <= cyl - 16'h0001;
        if (link.done === 1'b1) dones <= dones + 1;
        if (ego === 1'b1) goes <= goes + 1;
    end
    task report_and_stop;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read data stands in the access phase, so one read carries the answer
    task rd_reg(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task cmd(input logic [7:0] c, input logic [15:0] m, input logic [15:0] exp);
        int base, wi, g;
        base = dones;
        wi = 0;
        g = 0;
        apb(1'b1, REG_CMD, {24'h0, c});
        while (dones == base && g < 4000) begin
            g++;
            if (link.data_req === 1'b1 && wi < 256) begin
                apb(1'b1, REG_DATA, {16'h0, sec[wi]});
                wi++;
            end else @(posedge pclk);
        end
        if (g >= 4000) n_errors++;
        rd_reg(REG_RESULT);
        chk(rd[15:0] & m, exp);
    endtask
    task sector(input logic s, input logic [255:0] pw, input logic bad);
        sec[0] = 16'($random(seed));
        sec[0][0] = s;
        for (int i = 1; i < 256; i++)
            sec[i] = (i <= 16) ? pw[16*i-16 +: 16] : 16'($random(seed));
        if (bad) sec[9] = ~sec[9];
    endtask
    task setlock;
        @(posedge pclk);
        lock_set <= 1'b1;
        @(posedge pclk);
        lock_set <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        for (int i = 0; i < 8; i++) begin
            upw[32*i +: 32] = $random(seed);
            mpw[32*i +: 32] = $random(seed);
        end
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, REG_IRQ_EN, 32'h7);
        chk(16'(rerr), 16'h0);
        cmd(CMD_ERASE_ARM, 16'hffff, 16'h0050);
        chk(16'(irq), 16'h1);
        rd_reg(REG_IRQ_STAT);
        chk(16'(rd[IRQ_DONE]), 16'h1);
        apb(1'b1, REG_IRQ_CLR, 32'h7);
        @(posedge pclk);
        chk(16'(irq), 16'h0);
        cmd(CMD_ERASE_UNIT, 16'hffff, 16'h0050);
        chk(16'(goes), 16'h1);
        apb(1'b1, REG_IRQ_EN, 32'h0);
        cmd(CMD_ERASE_ARM, 16'hffff, 16'h0050);
        // Corner codes of the recalibrate family, then random ones
        for (int k = 0; k < 4; k++) begin
            cyl <= 16'($random(seed) & 32'hff);
            cmd({4'h1, k == 0 ? 4'h0 : k == 1 ? 4'hf : 4'($random(seed))},
                16'hffff, 16'h0050);
            chk(cyl, 16'h0);
        end
        chk(16'(irq), 16'h0);
        cmd(CMD_ERASE_UNIT, 16'hffff, 16'h0451);
        chk(16'(goes), 16'h1);
        apb(1'b1, 8'h1c, 32'h5);
        chk(16'(rerr), 16'h1);
        setlock();
        chk(16'(lock_en), 16'h1);
        for (int k = 0; k < 4; k++) begin
            if (k == 3) setlock();
            sector(k[0], k[0] ? mpw : upw, !k[1]);
            cmd(CMD_LOCK_DISABLE, 16'hffff, k[1] ? 16'h0050 : 16'h0451);
            chk(16'(lock_en), k[1] ? 16'h0 : 16'h1);
        end
        fault <= 1'b1;
        cyl <= 16'h0040;
        cmd(8'h1a, 16'hff01, 16'h0201);
        fault <= 1'b0;
        cmd(CMD_FREEZE, 16'hff00, 16'h0000);
        chk(16'(frozen), 16'h1);
        setlock();
        sector(1'b0, upw, 1'b0);
        cmd(CMD_LOCK_DISABLE, 16'hff01, 16'h0401);
        chk(16'(lock_en), 16'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
